// file: hw/sbs_serial_port.v
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.vh"

module sbs_serial_port (
    input  wire        core_clk_i,
    input  wire        rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        rx_i,
    input  wire        timer2_external_input_i,
    output reg         rx_o,
    output reg         rx_oe_o,
    output reg         tx_o,
    output reg         irq_o
);

    // ************************************************************
    // register state
    // ************************************************************
    reg [1:0]  mode_q;
    reg        address_filter_bit_q;
    reg        rx_en_q;
    reg        tx_ninth_q;
    reg        rx_ninth_bit_q;
    reg        tx_done_flag_q;
    reg        rx_done_flag_q;
    reg        timer1_fast_clock_bit_q;
    reg        m2_div32_q;
    reg [7:0]  timer1_reload_byte_q;
    reg        rx_baud_from_timer2_q;
    reg        tx_baud_from_timer2_q;
    reg        timer2_external_clock_select_q;
    reg [7:0]  timer2_reload_low_q;
    reg [7:0]  timer2_reload_high_q;
    reg [7:0]  rx_buf_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;

    // ************************************************************
    // apb decode
    // ************************************************************
    wire acc_w   = psel_i & penable_i & pready_o;
    wire wr_w    = acc_w & pwrite_i;
    wire rd_w    = acc_w & ~pwrite_i;
    wire hit_ctl = (paddr_i == `SBS_OFF_CTRL);
    wire hit_buf = (paddr_i == `SBS_OFF_BUF);
    wire hit_clk = (paddr_i == `SBS_OFF_CLKCTL);
    wire hit_t1  = (paddr_i == `SBS_OFF_T1RLD);
    wire hit_t2c = (paddr_i == `SBS_OFF_T2CTL);
    wire hit_t2l = (paddr_i == `SBS_OFF_T2RLDL);
    wire hit_t2h = (paddr_i == `SBS_OFF_T2RLDH);
    wire hit_ist = (paddr_i == `SBS_OFF_ISTAT);
    wire hit_imk = (paddr_i == `SBS_OFF_IMASK);
    wire mapped  = hit_ctl | hit_buf | hit_clk | hit_t1 | hit_t2c | hit_t2l | hit_t2h
                 | hit_ist | hit_imk;

    reg [7:0] rdata;
    always @* begin
        rdata = 8'h00;
        case (1'b1)
            hit_ctl: rdata = {mode_q, address_filter_bit_q, rx_en_q, tx_ninth_q,
                              rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
            hit_buf: rdata = rx_buf_q;
            hit_clk: rdata = {3'h0, timer1_fast_clock_bit_q, 3'h0, m2_div32_q};
            hit_t1:  rdata = timer1_reload_byte_q;
            hit_t2c: rdata = {2'h0, rx_baud_from_timer2_q, tx_baud_from_timer2_q, 2'h0,
                              timer2_external_clock_select_q, 1'b0};
            hit_t2l: rdata = timer2_reload_low_q;
            hit_t2h: rdata = timer2_reload_high_q;
            hit_ist: rdata = {6'h00, irq_stat_q};
            hit_imk: rdata = {6'h00, irq_mask_q};
            default: rdata = 8'h00;
        endcase
    end

    // one wait-free access phase: data is latched in the setup cycle
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (psel_i & ~penable_i) begin
            prdata_o  <= {24'h000000, rdata};
            pready_o  <= 1'b1;
            pslverr_o <= ~mapped;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    wire wr_ok = wr_w & mapped;

    // ************************************************************
    // timer 1: 8-bit reload baud timer
    // ************************************************************
    reg [3:0] t1_pre_q;
    reg [7:0] t1_cnt_q;
    reg       t1_ovf_q;
    wire      t1_inc = timer1_fast_clock_bit_q | (t1_pre_q == `SBS_T1_PRE_LAST);

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            t1_pre_q <= 4'h0;
            t1_cnt_q <= 8'h00;
            t1_ovf_q <= 1'b0;
        end else begin
            t1_pre_q <= (t1_pre_q == `SBS_T1_PRE_LAST) ? 4'h0 : t1_pre_q + 4'h1;
            t1_ovf_q <= t1_inc & (t1_cnt_q == 8'hFF);
            if (t1_inc)
                t1_cnt_q <= (t1_cnt_q == 8'hFF) ? timer1_reload_byte_q : t1_cnt_q + 8'h01;
        end
    end

    // ************************************************************
    // timer 2: 16-bit reload baud generator
    // ************************************************************
    // only baud generation exists here, so timer 2 never raises an interrupt
    reg        t2_half_q;
    reg        t2_ext_prev_q;
    reg [15:0] t2_cnt_q;
    reg        t2_ovf_q;
    wire       t2_on  = rx_baud_from_timer2_q | tx_baud_from_timer2_q;
    wire       t2_inc = t2_on & (timer2_external_clock_select_q ?
                        (timer2_external_input_i & ~t2_ext_prev_q) : t2_half_q);
    wire [15:0] t2_rld = {timer2_reload_high_q, timer2_reload_low_q};

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            t2_half_q     <= 1'b0;
            t2_ext_prev_q <= 1'b0;
            t2_cnt_q      <= 16'h0000;
            t2_ovf_q      <= 1'b0;
        end else begin
            t2_half_q     <= ~t2_half_q;
            t2_ext_prev_q <= timer2_external_input_i;
            t2_ovf_q      <= t2_inc & (t2_cnt_q == 16'hFFFF);
            if (t2_inc)
                t2_cnt_q <= (t2_cnt_q == 16'hFFFF) ? t2_rld : t2_cnt_q + 16'h0001;
        end
    end

    // ************************************************************
    // oversample ticks, 16 per bit
    // ************************************************************
    reg  [1:0] m2_cnt_q;
    wire [1:0] m2_last = m2_div32_q ? `SBS_M2_LAST_32 : `SBS_M2_LAST_64;
    wire       m2_tick = (m2_cnt_q == m2_last);
    wire       is_m2   = (mode_q == `SBS_MODE_A9FIX);
    wire       tx_tick = is_m2 ? m2_tick : (tx_baud_from_timer2_q ? t2_ovf_q : t1_ovf_q);
    wire       rx_tick = is_m2 ? m2_tick : (rx_baud_from_timer2_q ? t2_ovf_q : t1_ovf_q);

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i)
            m2_cnt_q <= 2'h0;
        else
            m2_cnt_q <= m2_tick ? 2'h0 : m2_cnt_q + 2'h1;
    end

    // ************************************************************
    // transmitter
    // ************************************************************
    wire       is_m0  = (mode_q == `SBS_MODE_SYNC);
    wire [3:0] nbits  = (mode_q == `SBS_MODE_A8) ? `SBS_BITS_A8 : `SBS_BITS_A9;
    reg        tx_busy_q;
    reg [10:0] tx_sh_q;
    reg [3:0]  tx_bits_q;
    reg [3:0]  tx_sub_q;
    reg        tx_set;
    reg        rx_busy_q;
    wire       tx_load = wr_w & hit_buf & ~tx_busy_q & ~(is_m0 & rx_busy_q);

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= 11'h7FF;
            tx_bits_q <= 4'h0;
            tx_sub_q  <= 4'h0;
            tx_set    <= 1'b0;
        end else begin
            tx_set <= 1'b0;
            if (tx_load) begin
                tx_busy_q <= 1'b1;
                tx_bits_q <= 4'h0;
                tx_sub_q  <= 4'h0;
                if (is_m0)
                    tx_sh_q <= {3'h7, pwdata_i[7:0]};
                else if (mode_q == `SBS_MODE_A8)
                    tx_sh_q <= {2'h3, pwdata_i[7:0], 1'b0};
                else
                    tx_sh_q <= {1'b1, tx_ninth_q, pwdata_i[7:0], 1'b0};
            end else if (tx_busy_q & is_m0) begin
                tx_sub_q <= (tx_sub_q == `SBS_M0_DIV_LAST) ? 4'h0 : tx_sub_q + 4'h1;
                if (tx_sub_q == `SBS_M0_DIV_LAST) begin
                    tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                    tx_bits_q <= tx_bits_q + 4'h1;
                    if (tx_bits_q == 4'h7) begin
                        tx_busy_q <= 1'b0;
                        tx_set    <= 1'b1;
                    end
                end
            end else if (tx_busy_q & tx_tick) begin
                tx_sub_q <= tx_sub_q + 4'h1;
                if (tx_sub_q == `SBS_OVS_LAST) begin
                    tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                    tx_bits_q <= tx_bits_q + 4'h1;
                    if (tx_bits_q == nbits - 4'h1) begin
                        tx_busy_q <= 1'b0;
                        tx_set    <= 1'b1;
                    end
                end
            end
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    reg [8:0] rx_sh_q;
    reg [3:0] rx_bits_q;
    reg [3:0] rx_sub_q;
    reg       rx_prev_q;
    reg       rx_m0_pend_q;
    reg       rx_set;
    reg [7:0] rx_data;
    reg       rx_nin;
    // rx_set covers the cycle before the receive-done flag becomes visible
    wire      m0_rx_go  = is_m0 & rx_en_q & ~rx_done_flag_q & ~rx_busy_q & ~rx_m0_pend_q
                          & ~rx_set & ~tx_busy_q & ~tx_load;
    wire      a_rx_go   = ~is_m0 & rx_en_q & ~rx_busy_q & rx_prev_q & ~rx_i;
    wire      rx_9bit   = (mode_q == `SBS_MODE_A9FIX) | (mode_q == `SBS_MODE_A9);
    wire      a_rx_keep = ~rx_done_flag_q &
                          (~rx_9bit | ~address_filter_bit_q | rx_sh_q[8]);

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_busy_q    <= 1'b0;
            rx_sh_q      <= 9'h000;
            rx_bits_q    <= 4'h0;
            rx_sub_q     <= 4'h0;
            rx_prev_q    <= 1'b1;
            rx_m0_pend_q <= 1'b0;
            rx_set       <= 1'b0;
            rx_data      <= 8'h00;
            rx_nin       <= 1'b0;
        end else begin
            rx_prev_q    <= rx_i;
            rx_set       <= 1'b0;
            rx_m0_pend_q <= 1'b0;
            if (rx_m0_pend_q) begin
                rx_set  <= 1'b1;
                rx_data <= rx_sh_q[8:1];
                rx_nin  <= rx_ninth_bit_q;
            end
            if (m0_rx_go | a_rx_go) begin
                rx_busy_q <= 1'b1;
                rx_bits_q <= 4'h0;
                rx_sub_q  <= 4'h0;
            end else if (rx_busy_q & is_m0) begin
                rx_sub_q <= (rx_sub_q == `SBS_M0_DIV_LAST) ? 4'h0 : rx_sub_q + 4'h1;
                if (rx_sub_q == `SBS_M0_DIV_LAST) begin
                    rx_sh_q   <= {rx_i, rx_sh_q[8:1]};
                    rx_bits_q <= rx_bits_q + 4'h1;
                    if (rx_bits_q == 4'h7) begin
                        rx_busy_q    <= 1'b0;
                        rx_m0_pend_q <= 1'b1;
                    end
                end
            end else if (rx_busy_q & rx_tick) begin
                rx_sub_q <= rx_sub_q + 4'h1;
                if (rx_sub_q == `SBS_OVS_MID) begin
                    rx_bits_q <= rx_bits_q + 4'h1;
                    if (rx_bits_q == 4'h0) begin
                        // a glitch that is high again at mid-bit is no start bit
                        if (rx_i)
                            rx_busy_q <= 1'b0;
                    end else if (rx_bits_q == nbits - 4'h1) begin
                        rx_busy_q <= 1'b0;
                        rx_set    <= a_rx_keep;
                        rx_data   <= rx_9bit ? rx_sh_q[7:0] : rx_sh_q[8:1];
                        rx_nin    <= rx_9bit ? rx_sh_q[8] : rx_ninth_bit_q;
                    end else begin
                        rx_sh_q <= {rx_i, rx_sh_q[8:1]};
                    end
                end
            end
        end
    end

    // ************************************************************
    // software registers, flags and interrupt
    // ************************************************************
    wire [1:0] irq_ev  = {rx_set, tx_set};
    wire [1:0] irq_clr = (rd_w & hit_ist) ? 2'h3 : 2'h0;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q                         <= `SBS_MODE_SYNC;
            address_filter_bit_q           <= 1'b0;
            rx_en_q                        <= 1'b0;
            tx_ninth_q                     <= 1'b0;
            rx_ninth_bit_q                 <= 1'b0;
            tx_done_flag_q                 <= 1'b0;
            rx_done_flag_q                 <= 1'b0;
            timer1_fast_clock_bit_q        <= 1'b0;
            m2_div32_q                     <= `SBS_RST_M2DIV32;
            timer1_reload_byte_q           <= 8'h00;
            rx_baud_from_timer2_q          <= 1'b0;
            tx_baud_from_timer2_q          <= 1'b0;
            timer2_external_clock_select_q <= 1'b0;
            timer2_reload_low_q            <= 8'h00;
            timer2_reload_high_q           <= 8'h00;
            rx_buf_q                       <= 8'h00;
            irq_stat_q                     <= 2'h0;
            irq_mask_q                     <= 2'h0;
            irq_o                          <= 1'b0;
        end else begin
            if (wr_ok & hit_ctl) begin
                mode_q               <= pwdata_i[`SBS_CTRL_MODE_HI:`SBS_CTRL_MODE_LO];
                address_filter_bit_q <= pwdata_i[`SBS_CTRL_ADDRF];
                rx_en_q              <= pwdata_i[`SBS_CTRL_REN];
                tx_ninth_q           <= pwdata_i[`SBS_CTRL_TX9];
            end
            // a hardware set in the same cycle beats the software write
            if (tx_set)
                tx_done_flag_q <= 1'b1;
            else if (wr_ok & hit_ctl)
                tx_done_flag_q <= pwdata_i[`SBS_CTRL_TXDONE];
            if (rx_set) begin
                rx_done_flag_q <= 1'b1;
                rx_buf_q       <= rx_data;
                rx_ninth_bit_q <= rx_nin;
            end else if (wr_ok & hit_ctl) begin
                rx_done_flag_q <= pwdata_i[`SBS_CTRL_RXDONE];
            end
            if (wr_ok & hit_clk) begin
                timer1_fast_clock_bit_q <= pwdata_i[`SBS_CLK_T1FAST];
                m2_div32_q              <= pwdata_i[`SBS_CLK_M2DIV32];
            end
            if (wr_ok & hit_t1)
                timer1_reload_byte_q <= pwdata_i[7:0];
            if (wr_ok & hit_t2c) begin
                rx_baud_from_timer2_q          <= pwdata_i[`SBS_T2_RXSEL];
                tx_baud_from_timer2_q          <= pwdata_i[`SBS_T2_TXSEL];
                timer2_external_clock_select_q <= pwdata_i[`SBS_T2_EXTCLK];
            end
            if (wr_ok & hit_t2l)
                timer2_reload_low_q <= pwdata_i[7:0];
            if (wr_ok & hit_t2h)
                timer2_reload_high_q <= pwdata_i[7:0];
            if (wr_ok & hit_imk)
                irq_mask_q <= pwdata_i[1:0];
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
            irq_o      <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_mask_q);
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    wire m0_clk_low = is_m0 & ((tx_busy_q & (tx_sub_q < `SBS_M0_CLK_HIGH)) |
                               (rx_busy_q & (rx_sub_q < `SBS_M0_CLK_HIGH)));

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_o    <= 1'b1;
            rx_o    <= 1'b1;
            rx_oe_o <= 1'b0;
        end else begin
            tx_o    <= is_m0 ? ~m0_clk_low : tx_sh_q[0];
            rx_o    <= tx_sh_q[0];
            rx_oe_o <= is_m0 & tx_busy_q;
        end
    end

endmodule

`default_nettype wire

// file: hw/sbs_defines.vh
// Notes on behaviour
// - four serial modes picked by control bits; mode 0 is synchronous, 8 bits, clock/12.
// - modes 1 and 3 frame with start and stop; 8 or 9 bits; timer overflow timed.
// - mode 2 carries 9 data bits framed; bit clock is system clock /32 or /64.
// - mode 0 is half-duplex master; data on receive pin, shift clock on transmit pin.
// - mode 0 shifts exactly eight bits, least significant first, both directions.
// - mode 0 transmission starts on a write to the serial buffer register while neither transmit nor receive is busy.
// - mode 0 sets the transmit-done flag when the eighth bit time ends.
// - mode 0 reception starts only with receive enable at 1 and receive-done at 0.
// - mode 0 sets receive-done one cycle after bit eight, then waits for a clear.
// - an enabled interrupt request is raised whenever transmit-done or receive-done sets; here only a hardware set raises it, not a software write.
// - timer 1 overflows at clock/(256-reload), or clock/12/(256-reload) with fast bit clear.
// - timer 2 runs at clock/2 and overflows every (65536-reload) counts.
// - timer 2 select bits pick its overflow as receive and transmit baud clocks.
// - with a timer 2 select bit set, timer 2 is forced to baud mode without interrupts.
// - timer 2 external clock select counts the external input pin instead.
// - with address filter set in modes 2 and 3, receive completes only if the ninth bit is 1.
`ifndef SBS_DEFINES_VH
`define SBS_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define SBS_OFF_CTRL     8'h00
`define SBS_OFF_BUF      8'h04
`define SBS_OFF_CLKCTL   8'h08
`define SBS_OFF_T1RLD    8'h0C
`define SBS_OFF_T2CTL    8'h10
`define SBS_OFF_T2RLDL   8'h14
`define SBS_OFF_T2RLDH   8'h18
`define SBS_OFF_ISTAT    8'h1C
`define SBS_OFF_IMASK    8'h20

// ************************************************************
// field positions
// ************************************************************
`define SBS_CTRL_MODE_HI 7
`define SBS_CTRL_MODE_LO 6
`define SBS_CTRL_ADDRF   5
`define SBS_CTRL_REN     4
`define SBS_CTRL_TX9     3
`define SBS_CTRL_RX9     2
`define SBS_CTRL_TXDONE  1
`define SBS_CTRL_RXDONE  0
`define SBS_CLK_T1FAST   4
`define SBS_CLK_M2DIV32  0
`define SBS_T2_RXSEL     5
`define SBS_T2_TXSEL     4
`define SBS_T2_EXTCLK    1
`define SBS_IRQ_TX       0
`define SBS_IRQ_RX       1

// ************************************************************
// modes, reset values and timing counts
// ************************************************************
`define SBS_MODE_SYNC    2'h0
`define SBS_MODE_A8      2'h1
`define SBS_MODE_A9FIX   2'h2
`define SBS_MODE_A9      2'h3
`define SBS_RST_CTRL     8'h00
`define SBS_RST_M2DIV32  1'b0
`define SBS_M0_DIV_LAST  4'hB
`define SBS_M0_CLK_HIGH  4'h6
`define SBS_T1_PRE_LAST  4'hB
`define SBS_M2_LAST_32   2'h1
`define SBS_M2_LAST_64   2'h3
`define SBS_OVS_MID      4'h7
`define SBS_OVS_LAST     4'hF
`define SBS_BITS_A8      4'hA
`define SBS_BITS_A9      4'hB

`endif

// file: bench/sbs_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.vh"
module sbs_port_props (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        rx_i,
    input wire logic        timer2_external_input_i,
    input wire logic        rx_o,
    input wire logic        rx_oe_o,
    input wire logic        tx_o,
    input wire logic        irq_o
);
    logic [7:0] oe_cnt_q;
    logic [7:0] oe_cnt_d;
    // counts how long the data pin stays driven, one count per clock
    assign oe_cnt_d = rx_oe_o ? oe_cnt_q + 8'h01 : 8'h00;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) oe_cnt_q <= 8'h00;
        else oe_cnt_q <= oe_cnt_d;
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    property p_rdy; (psel_i && !penable_i) |=> pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_rdy_one; pready_o |=> !pready_o; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
    property p_err; (psel_i && !penable_i && paddr_i > `SBS_OFF_IMASK) |=>
        pslverr_o && prdata_o == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_upper; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_mask; (psel_i && penable_i && pready_o && pwrite_i && paddr_i ==
        `SBS_OFF_IMASK && pwdata_i[1:0] == 2'h0) |-> ##2 !irq_o; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt still high");
    property p_oe_clk; $rose(rx_oe_o) |-> !tx_o; endproperty
    a_oe_clk: assert property (p_oe_clk) else $error("shift clock not low at start");
    property p_bit_time; ($fell(tx_o) && rx_oe_o) |-> (!tx_o)[*6] ##1 tx_o[*6]; endproperty
    a_bit_time: assert property (p_bit_time) else $error("shift clock shape wrong");
    property p_len; $fell(rx_oe_o) |-> oe_cnt_q == 8'h60; endproperty
    a_len: assert property (p_len) else $error("transmit length not eight bits");
    property p_data; (rx_oe_o && $changed(rx_o)) |-> $fell(tx_o); endproperty
    a_data: assert property (p_data) else $error("data moved off clock fall");
    c_tx: cover property ($fell(rx_oe_o));
    c_irq: cover property ($rose(irq_o));
    c_err: cover property (pslverr_o);
endmodule
bind sbs_serial_port sbs_port_props i_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i), .rx_o(rx_o),
    .timer2_external_input_i(timer2_external_input_i), .rx_oe_o(rx_oe_o), .tx_o(tx_o),
    .irq_o(irq_o));
`default_nettype wire

// file: bench/sbs_far_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_far_peer (
    input  wire logic       core_clk_i,
    input  wire logic       shift_clk_i,
    input  wire logic       line_i,
    input  wire logic       oe_i,
    output var  logic       line_o,
    output var  logic [7:0] cap_o
);
    logic [7:0] peer_q;
    logic       clk_q;
    initial begin
        line_o = 1'b1;
        peer_q = 8'hFF;
        cap_o = 8'h00;
        clk_q = 1'b1;
    end
    always @(posedge core_clk_i) begin
        clk_q <= shift_clk_i;
        // present next bit on each shift clock fall while the port listens
        if (clk_q && !shift_clk_i && !oe_i) begin
            line_o <= peer_q[0];
            peer_q <= {1'b1, peer_q[7:1]};
        end
        if (!clk_q && shift_clk_i) cap_o <= {line_i, cap_o[7:1]};
    end
    task load(input logic [7:0] b);
        peer_q <= b;
    endtask
    // idle line sits high, as the pull-up would leave it
    task release_line;
        line_o <= 1'b1;
    endtask
    // ninth bit is 1 for an address, 0 for data
    task send_frame(input logic [8:0] d, input integer nbits, input integer per);
        integer i;
        for (i = 0; i < nbits + 2; i = i + 1) begin
            line_o <= (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : d[i-1];
            repeat (per) @(posedge core_clk_i);
        end
    endtask
endmodule
`default_nettype wire

// file: bench/tb_serial_port_with_baud_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defines.vh"
module tb_serial_port_with_baud_select;
    logic        clk, rst, psel, pen, pwr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, rxo, rxoe, txo, irq, peer_line, rx_wire;
    wire  [7:0]  cap;
    integer      n_errors = 0, n_checks = 0, k;
    assign rx_wire = rxoe ? rxo : peer_line;
    sbs_serial_port i_dut (
        .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .rx_i(rx_wire), .timer2_external_input_i(1'b0), .rx_o(rxo),
        .rx_oe_o(rxoe), .tx_o(txo), .irq_o(irq));
    sbs_far_peer i_peer (.core_clk_i(clk), .shift_clk_i(txo), .line_i(rx_wire),
        .oe_i(rxoe), .line_o(peer_line), .cap_o(cap));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one transfer, then one idle edge so no signal is assigned twice at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 50);
        check(32'(pready), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task wait_irq;
        integer n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n = n + 1;
        end
    endtask
    task give_verdict;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors = n_errors + 1;
        give_verdict;
    end
    initial begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(32'(txo), 32'h1);
        apb(0, `SBS_OFF_CTRL, 0); check(rd, 32'h0);
        apb(0, `SBS_OFF_CLKCTL, 0); check(rd, 32'h0);
        apb(0, 8'h40, 0); check({rd[30:0], err}, 32'h1);
        $display("test reset done");
        apb(1, `SBS_OFF_IMASK, 32'h3);
        apb(1, `SBS_OFF_BUF, 32'hA5);
        wait_irq; check(32'(irq), 32'h1);
        check(32'(cap), 32'hA5);
        apb(0, `SBS_OFF_CTRL, 0); check(rd, 32'h2);
        apb(0, `SBS_OFF_ISTAT, 0); check(rd, 32'h1);
        apb(1, `SBS_OFF_CTRL, 0); check(32'(irq), 32'h0);
        $display("test sync transmit done");
        i_peer.load(8'h3C);
        apb(1, `SBS_OFF_CTRL, 32'h10);
        wait_irq; check(32'(irq), 32'h1);
        apb(0, `SBS_OFF_BUF, 0); check(rd, 32'h3C);
        apb(0, `SBS_OFF_CTRL, 0); check(rd, 32'h11);
        repeat (40) @(posedge clk);
        check(32'(txo), 32'h1);
        apb(0, `SBS_OFF_ISTAT, 0); check(rd, 32'h2);
        apb(1, `SBS_OFF_CTRL, 0);
        i_peer.release_line;
        $display("test sync receive done");
        apb(1, `SBS_OFF_CLKCTL, 32'h1);
        apb(1, `SBS_OFF_CTRL, 32'hB0);
        i_peer.send_frame(9'h055, 9, 32);
        apb(0, `SBS_OFF_CTRL, 0); check(rd, 32'hB0);
        i_peer.send_frame(9'h1AA, 9, 32);
        apb(0, `SBS_OFF_CTRL, 0); check(rd, 32'hB5);
        apb(0, `SBS_OFF_BUF, 0); check(rd, 32'hAA);
        $display("test address filter done");
        apb(1, `SBS_OFF_T1RLD, 32'hFF);
        // timer 1 must roll over once before the new reload sets the tick rate
        repeat (3100) @(posedge clk);
        for (k = 0; k < 2; k = k + 1) begin
            apb(1, `SBS_OFF_CLKCTL, (k == 0) ? 32'h0 : 32'h10);
            apb(1, `SBS_OFF_CTRL, 32'h50);
            i_peer.send_frame(9'h0C3 ^ k[8:0], 8, (k == 0) ? 192 : 16);
            apb(0, `SBS_OFF_BUF, 0); check(rd, 32'hC3 ^ k);
            apb(0, `SBS_OFF_CTRL, 0); check(rd, 32'h55);
        end
        $display("test timer baud done");
        apb(1, `SBS_OFF_BUF, 32'h96);
        repeat (8) @(posedge clk);
        for (k = 0; k < 10; k = k + 1) begin
            rd[k] = txo;
            repeat (16) @(posedge clk);
        end
        check({22'h0, rd[9:0]}, 32'h32C);
        $display("test async transmit done");
        apb(1, `SBS_OFF_IMASK, 0);
        @(posedge clk);
        check(32'(irq), 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
